// File: sehc_top.sv
// Purpose: status and event command handling for a remote-control link
// Assumes: commands arrive parsed, one per handshake, in line order
// Notes:   replies are binary plus decimal digits; text framing is outside
`timescale 1ns/100ps
`default_nettype none
`include "sehc_regs.svh"

module sehc_top (
    // clock and reset
    input  wire logic                     CLK_IN,
    input  wire logic                     RST_IN,
    // link variant: high for the serial port, low for the instrument bus
    input  wire logic                     LINK_SERIAL_IN,
    // command stream from the parser
    input  wire logic                     CMD_VALID_IN,
    input  wire sehc_pkg::sehc_cmd_t      CMD_CODE_IN,
    input  wire logic [`SEHC_REG_W-1:0]   CMD_DATA_IN,
    output logic                          CMD_READY_OUT,
    // dispatch of other commands to the instrument core
    output logic                          EXEC_START_OUT,
    output logic      [`SEHC_REG_W-1:0]   EXEC_DATA_OUT,
    input  wire logic                     EXEC_BUSY_IN,
    // event sources, one pulse per event, bit order as the status register
    input  wire logic [`SEHC_REG_W-1:0]   EVENT_IN,
    // status byte side
    output logic                          STATUS_CLEAR_OUT,
    output logic                          SUMMARY_OUT,
    output logic      [`SEHC_REG_W-1:0]   EVENT_STATUS_OUT,
    // query reply
    output logic                          REPLY_VALID_OUT,
    output logic      [`SEHC_REG_W-1:0]   REPLY_BIN_OUT,
    output logic      [3:0]               REPLY_HUND_OUT,
    output logic      [3:0]               REPLY_TENS_OUT,
    output logic      [3:0]               REPLY_ONES_OUT,
    input  wire logic                     REPLY_READY_IN
);

    import sehc_pkg::*;

    sehc_state_t              state;        // controller state
    sehc_state_t              next_state;   // its next value
    logic                     drain_opc;    // drain ends by marking opc
    logic [`SEHC_REG_W-1:0]   enable_mask;  // event enable mask
    logic [`SEHC_REG_W-1:0]   event_status; // event status register
    logic [`SEHC_REG_W-1:0]   next_status;  // next status value

    wire logic                take;         // command accepted this cycle
    wire logic                is_other;     // decoded commands
    wire logic                is_wait;
    wire logic                is_cls;
    wire logic                is_esew;
    wire logic                is_eseq;
    wire logic                is_esrq;
    wire logic                is_opc;
    wire logic                core_idle;    // all earlier commands done
    wire logic                drain_done;   // drain state may end
    wire logic                reply_ack;    // reply taken by the link
    wire logic                dec_load;     // start a reply
    wire logic [`SEHC_REG_W-1:0] dec_value; // value to reply with
    wire logic [`SEHC_REG_W-1:0] used_mask; // bits that exist on this link
    wire logic [`SEHC_REG_W-1:0] set_bits;  // events landing this cycle
    wire logic                status_clr;   // status cleared this cycle
    wire logic [`SEHC_REG_W-1:0] next_mask; // mask as of the next edge

    // command decode
    assign take     = CMD_VALID_IN & CMD_READY_OUT;
    assign is_other = take & (CMD_CODE_IN == SEHC_CMD_OTHER);
    assign is_wait  = take & (CMD_CODE_IN == SEHC_CMD_WAIT);
    assign is_cls   = take & (CMD_CODE_IN == SEHC_CMD_CLS);
    assign is_esew  = take & (CMD_CODE_IN == SEHC_CMD_ESEW);
    assign is_eseq  = take & (CMD_CODE_IN == SEHC_CMD_ESEQ);
    assign is_esrq  = take & (CMD_CODE_IN == SEHC_CMD_ESRQ);
    assign is_opc   = take & (CMD_CODE_IN == SEHC_CMD_OPC);

    // the core raises busy in the same cycle it sees a start pulse, so a
    // start still on the wire counts as unfinished work
    assign core_idle  = ~EXEC_BUSY_IN & ~EXEC_START_OUT;
    assign drain_done = (state == SEHC_ST_DRAIN) & core_idle;
    assign reply_ack  = REPLY_VALID_OUT & REPLY_READY_IN;

    // replies carry the plain binary value; its decimal digits follow
    assign dec_load  = is_eseq | is_esrq;
    assign dec_value = is_esrq ? event_status : enable_mask;

    // mask as it stands after this edge, so the summary never lags a write
    assign next_mask = is_esew ? CMD_DATA_IN : enable_mask;

    // serial variant has no bits 6, 1 and 0 in the status register
    assign used_mask = LINK_SERIAL_IN ? `SEHC_SERIAL_USED : 8'hff;

    // opc bit joins the event inputs once the drain for it completes
    assign set_bits = (EVENT_IN |
                       ({7'h00, drain_done & drain_opc} << `SEHC_BIT_OPC))
                      & used_mask;

    // a read of the status register or a clear-status both empty it
    assign status_clr = is_esrq | is_cls;

    // next status: cleared on command, but an event in the same cycle wins
    always_comb begin
        next_status = event_status;
        if (status_clr) begin
            next_status = 8'h00;
        end
        next_status = next_status | set_bits;
    end

    // next state: wait and opc drain, queries hold for the reply
    always_comb begin
        next_state = state;
        unique case (state)
            SEHC_ST_IDLE: begin
                if (is_wait | is_opc) begin
                    next_state = SEHC_ST_DRAIN;
                end else if (dec_load) begin
                    next_state = SEHC_ST_REPLY;
                end
            end
            SEHC_ST_DRAIN: begin
                if (core_idle) begin
                    next_state = SEHC_ST_IDLE;
                end
            end
            SEHC_ST_REPLY: begin
                if (reply_ack) begin
                    next_state = SEHC_ST_IDLE;
                end
            end
        endcase
    end

    // state register; ready follows the state so later commands stall
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            state         <= SEHC_ST_IDLE;
            CMD_READY_OUT <= 1'b1;
        end else begin
            state         <= next_state;
            CMD_READY_OUT <= (next_state == SEHC_ST_IDLE);
        end
    end

    // remember whether the pending drain belongs to an opc marker
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            drain_opc <= 1'b0;
        end else if (take) begin
            drain_opc <= is_opc;
        end
    end

    // enable mask: only its own write changes it, never clear-status
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            enable_mask <= `SEHC_MASK_RESET;
        end else if (is_esew) begin
            enable_mask <= CMD_DATA_IN;
        end
    end

    // event status register
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            event_status <= `SEHC_STATUS_RESET;
        end else begin
            event_status <= next_status;
        end
    end

    // dispatch of ordinary commands; data passes through registered
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            EXEC_START_OUT <= 1'b0;
            EXEC_DATA_OUT  <= 8'h00;
        end else begin
            EXEC_START_OUT <= is_other;
            if (is_other) begin
                EXEC_DATA_OUT <= CMD_DATA_IN;
            end
        end
    end

    // status byte side; clear pulse tells other event registers to clear,
    // the message-available bit and output queue are not ours to touch
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            STATUS_CLEAR_OUT <= 1'b0;
            SUMMARY_OUT      <= 1'b0;
            EVENT_STATUS_OUT <= `SEHC_STATUS_RESET;
        end else begin
            STATUS_CLEAR_OUT <= is_cls;
            SUMMARY_OUT      <= |(next_status & next_mask);
            EVENT_STATUS_OUT <= next_status;
        end
    end

    // reply register and decimal digits; stands until taken
    sehc_dec u_dec (
        .clk_in    (CLK_IN),
        .rst_in    (RST_IN),
        .load_in   (dec_load),
        .value_in  (dec_value),
        .ack_in    (reply_ack),
        .valid_out (REPLY_VALID_OUT),
        .bin_out   (REPLY_BIN_OUT),
        .hund_out  (REPLY_HUND_OUT),
        .tens_out  (REPLY_TENS_OUT),
        .ones_out  (REPLY_ONES_OUT)
    );

endmodule : sehc_top
`default_nettype wire

// File: sehc_regs.svh
// Purpose: constants for the status and event command handler
// Assumes: included by its bare name from the design files
// Notes:   definitions only; values are widths, bit positions, masks, resets and divisors
`ifndef SEHC_REGS_SVH
`define SEHC_REGS_SVH

// register width shared by both event registers
`define SEHC_REG_W          8

// bit positions of both event registers, bit 7 down to bit 0
`define SEHC_BIT_PON        7
`define SEHC_BIT_URQ        6
`define SEHC_BIT_CME        5
`define SEHC_BIT_EXE        4
`define SEHC_BIT_DDE        3
`define SEHC_BIT_QYE        2
`define SEHC_BIT_RQC        1
`define SEHC_BIT_OPC        0

// bits that exist on the serial link variant (6, 1 and 0 unused)
`define SEHC_SERIAL_USED    8'hbc

// reset values: mask starts empty, status shows the power-on event
`define SEHC_MASK_RESET     8'h00
`define SEHC_STATUS_RESET   8'h80

// decimal conversion divisors
`define SEHC_DEC_HUNDRED    8'h64
`define SEHC_DEC_TEN        8'h0a

`endif

// File: sehc_pkg.sv
// Purpose: types of the status and event command handler
// Assumes: none
// Notes:   command and state encodings only; numbers live in the header
package sehc_pkg;

    // command codes presented by the command line parser
    typedef enum logic [2:0] {
        SEHC_CMD_OTHER = 3'h0,  // any instrument command, dispatched on
        SEHC_CMD_WAIT  = 3'h1,  // hold following commands until idle
        SEHC_CMD_CLS   = 3'h2,  // clear status
        SEHC_CMD_ESEW  = 3'h3,  // write event enable mask
        SEHC_CMD_ESEQ  = 3'h4,  // query event enable mask
        SEHC_CMD_ESRQ  = 3'h5,  // read and clear event status
        SEHC_CMD_OPC   = 3'h6   // mark operation complete when idle
    } sehc_cmd_t;

    // controller states, one-hot
    typedef enum logic [2:0] {
        SEHC_ST_IDLE  = 3'b001, // accepting commands
        SEHC_ST_DRAIN = 3'b010, // waiting for earlier commands to finish
        SEHC_ST_REPLY = 3'b100  // holding a reply until taken
    } sehc_state_t;

endpackage : sehc_pkg

// File: sehc_dec.sv
// Purpose: register an 8-bit value as binary and as three decimal digits
// Assumes: load is a one-cycle pulse; ack is valid and ready together
// Notes:   reply holds stable until acknowledged
`timescale 1ns/100ps
`default_nettype none
`include "sehc_regs.svh"

module sehc_dec (
    // clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     rst_in,
    // request
    input  wire logic                     load_in,
    input  wire logic [`SEHC_REG_W-1:0]   value_in,
    input  wire logic                     ack_in,
    // reply
    output logic                          valid_out,
    output logic      [`SEHC_REG_W-1:0]   bin_out,
    output logic      [3:0]               hund_out,
    output logic      [3:0]               tens_out,
    output logic      [3:0]               ones_out
);

    wire logic [7:0] rem_hund;   // value below one hundred
    wire logic [7:0] q_hund;     // hundreds quotient
    wire logic [7:0] q_tens;     // tens quotient
    wire logic [7:0] q_ones;     // units remainder

    // weighted sum is just the binary value; digits for the text reply
    assign q_hund   = value_in / `SEHC_DEC_HUNDRED;
    assign rem_hund = value_in % `SEHC_DEC_HUNDRED;
    assign q_tens   = rem_hund / `SEHC_DEC_TEN;
    assign q_ones   = rem_hund % `SEHC_DEC_TEN;

    // capture on load, hold until the consumer takes it
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            valid_out <= 1'b0;
            bin_out   <= 8'h00;
            hund_out  <= 4'h0;
            tens_out  <= 4'h0;
            ones_out  <= 4'h0;
        end else if (load_in) begin
            valid_out <= 1'b1;
            bin_out   <= value_in;
            hund_out  <= q_hund[3:0];
            tens_out  <= q_tens[3:0];
            ones_out  <= q_ones[3:0];
        end else if (ack_in) begin
            valid_out <= 1'b0;
        end
    end

endmodule : sehc_dec
`default_nettype wire

// File: sehc_core.sv
// Purpose: behavioural instrument core behind the dispatch port
// Assumes: busy rises with the start pulse, as the handler expects
// Notes:   low nibble of the payload sets how long the core stays busy
`timescale 1ns/100ps
`default_nettype none

module sehc_core (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // dispatch from the handler
    input  wire logic       start_in,
    input  wire logic [7:0] data_in,
    output logic            busy_out
);
    logic [3:0] cnt;  // cycles of work left after the start cycle

    // busy in the start cycle itself, so no drain can slip through
    assign busy_out = start_in | (cnt != 4'h0);

    // load the work length, then count it down
    always_ff @(posedge clk_in) begin
        if (rst_in)
            cnt <= 4'h0;
        else if (start_in)
            cnt <= data_in[3:0];
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
    end
endmodule : sehc_core

`default_nettype wire

// File: sehc_top_sva.sv
// Purpose: port assertions for the status and event handler
// Assumes: one clock domain, synchronous active-high reset
// Notes:   link variant is changed only while status is clear
`timescale 1ns/100ps
`default_nettype none

module sehc_chk
    import sehc_pkg::*;
(
    // clock, reset, link
    input wire logic       CLK_IN, RST_IN, LINK_SERIAL_IN,
    // command and dispatch
    input wire logic       CMD_VALID_IN, CMD_READY_OUT,
    input wire sehc_cmd_t  CMD_CODE_IN,
    input wire logic [7:0] CMD_DATA_IN, EXEC_DATA_OUT,
    input wire logic       EXEC_START_OUT, EXEC_BUSY_IN,
    // status and reply
    input wire logic [7:0] EVENT_IN, EVENT_STATUS_OUT, REPLY_BIN_OUT,
    input wire logic       STATUS_CLEAR_OUT, REPLY_VALID_OUT,
    input wire logic [3:0] REPLY_HUND_OUT, REPLY_TENS_OUT, REPLY_ONES_OUT,
    input wire logic       REPLY_READY_IN
);
    wire logic       tk = CMD_VALID_IN && CMD_READY_OUT;  // command taken
    wire logic [7:0] msk = LINK_SERIAL_IN ? 8'hbc : 8'hff; // settable bits
    wire logic       idle = !CMD_READY_OUT && !REPLY_VALID_OUT;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    sequence s_take(sehc_cmd_t c);
        tk && CMD_CODE_IN == c;
    endsequence

    property p_hold;
        REPLY_VALID_OUT && !REPLY_READY_IN |=>
            REPLY_VALID_OUT && $stable(REPLY_BIN_OUT);
    endproperty
    a_hold: assert property (p_hold) else $error("reply dropped");
    property p_dec;
        REPLY_VALID_OUT |-> REPLY_HUND_OUT * 10'd100 + REPLY_TENS_OUT *
            10'd10 + REPLY_ONES_OUT == {2'h0, REPLY_BIN_OUT};
    endproperty
    a_dec: assert property (p_dec) else $error("bad digits");
    property p_esr;
        s_take(SEHC_CMD_ESRQ) |=> REPLY_VALID_OUT &&
            REPLY_BIN_OUT == $past(EVENT_STATUS_OUT) &&
            EVENT_STATUS_OUT == ($past(EVENT_IN) & msk);
    endproperty
    a_esr: assert property (p_esr) else $error("status read");
    property p_cls;
        s_take(SEHC_CMD_CLS) |=> STATUS_CLEAR_OUT &&
            EVENT_STATUS_OUT == ($past(EVENT_IN) & msk);
    endproperty
    a_cls: assert property (p_cls) else $error("clear status");
    property p_ese;
        s_take(SEHC_CMD_ESEW) ##1 s_take(SEHC_CMD_ESEQ) |=>
            REPLY_BIN_OUT == $past(CMD_DATA_IN, 2);
    endproperty
    a_ese: assert property (p_ese) else $error("mask echo");
    property p_wait;
        s_take(SEHC_CMD_WAIT) |=> !CMD_READY_OUT;
    endproperty
    a_wait: assert property (p_wait) else $error("wait ignored");
    property p_drain;
        idle && EXEC_BUSY_IN |=> !CMD_READY_OUT;
    endproperty
    a_drain: assert property (p_drain) else $error("early resume");
    property p_resume;
        idle && !EXEC_BUSY_IN && !EXEC_START_OUT |=> CMD_READY_OUT;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume");
    property p_exec;
        s_take(SEHC_CMD_OTHER) |=> EXEC_START_OUT && CMD_READY_OUT &&
            EXEC_DATA_OUT == $past(CMD_DATA_IN);
    endproperty
    a_exec: assert property (p_exec) else $error("bad dispatch");
    property p_serial;
        LINK_SERIAL_IN |-> (EVENT_STATUS_OUT & 8'h43) == 8'h00;
    endproperty
    a_serial: assert property (p_serial) else $error("unused bit");
endmodule : sehc_chk

bind sehc_top sehc_chk u_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
    .LINK_SERIAL_IN(LINK_SERIAL_IN), .CMD_VALID_IN(CMD_VALID_IN),
    .CMD_READY_OUT(CMD_READY_OUT), .CMD_CODE_IN(CMD_CODE_IN),
    .CMD_DATA_IN(CMD_DATA_IN), .EXEC_DATA_OUT(EXEC_DATA_OUT),
    .EXEC_START_OUT(EXEC_START_OUT), .EXEC_BUSY_IN(EXEC_BUSY_IN),
    .EVENT_IN(EVENT_IN), .EVENT_STATUS_OUT(EVENT_STATUS_OUT),
    .REPLY_BIN_OUT(REPLY_BIN_OUT), .STATUS_CLEAR_OUT(STATUS_CLEAR_OUT),
    .REPLY_VALID_OUT(REPLY_VALID_OUT), .REPLY_HUND_OUT(REPLY_HUND_OUT),
    .REPLY_TENS_OUT(REPLY_TENS_OUT), .REPLY_ONES_OUT(REPLY_ONES_OUT),
    .REPLY_READY_IN(REPLY_READY_IN));

`default_nettype wire

// File: test_status_event_command_handling.sv
// Purpose: directed command sequences against the handler
// Assumes: tasks are entered just after a clock edge
// Notes:   link variant switches only while status is clear
`timescale 1ns/100ps
`default_nettype none

module test_status_event_command_handling;
    import sehc_pkg::*;
    logic       clk = 1'b0, rst = 1'b1, ser = 1'b0, cv = 1'b0, rr = 1'b0;
    sehc_cmd_t  cc = SEHC_CMD_OTHER;
    logic [7:0] cd = 8'h00, ev = 8'h00, xd, est, rb;
    logic       crd, xs, busy, sclr, summ, rv;
    logic [3:0] rh, rt, ro;
    logic [7:0] vals [3] = '{8'h00, 8'h24, 8'hff}; // mask corners
    bit         held = 1'b0;  // valid still up from a back-to-back call
    int         n_mismatch = 0, total_checks = 0, i, k;

    sehc_top uut (.CLK_IN(clk), .RST_IN(rst), .LINK_SERIAL_IN(ser),
        .CMD_VALID_IN(cv), .CMD_CODE_IN(cc), .CMD_DATA_IN(cd),
        .CMD_READY_OUT(crd), .EXEC_START_OUT(xs), .EXEC_DATA_OUT(xd),
        .EXEC_BUSY_IN(busy), .EVENT_IN(ev), .STATUS_CLEAR_OUT(sclr),
        .SUMMARY_OUT(summ), .EVENT_STATUS_OUT(est), .REPLY_VALID_OUT(rv),
        .REPLY_BIN_OUT(rb), .REPLY_HUND_OUT(rh), .REPLY_TENS_OUT(rt),
        .REPLY_ONES_OUT(ro), .REPLY_READY_IN(rr));
    sehc_core core (.clk_in(clk), .rst_in(rst), .start_in(xs),
        .data_in(xd), .busy_out(busy));

    initial forever #20 clk = ~clk;

    task automatic check(input string what, input logic [9:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %0d seen %0d", what, exp, seen);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // present a command and hold it until the edge that takes it
    task automatic cmd(input sehc_cmd_t c, input logic [7:0] d, input bit b);
        if (!held) @(posedge clk);
        cv <= 1'b1;
        cc <= c;
        cd <= d;
        @(negedge clk);
        for (k = 0; k < 60 && crd !== 1'b1; k++) @(negedge clk);
        if (k == 60) begin
            check("ready wait", 10'h0, 10'h1);
            test_done();
        end
        @(posedge clk);
        held = b;
        if (!b) cv <= 1'b0;
    endtask : cmd

    // query, compare the reply, then acknowledge it two cycles late
    task automatic rd(input sehc_cmd_t c, input logic [7:0] e, string w);
        cmd(c, 8'h00, 1'b0);
        @(negedge clk);
        for (k = 0; k < 60 && rv !== 1'b1; k++) @(negedge clk);
        if (k == 60) begin
            check("reply wait", 10'h0, 10'h1);
            test_done();
        end
        check(w, rb, e);
        check("digits", rh * 10'd100 + rt * 10'd10 + ro, e);
        @(posedge clk);
        @(posedge clk);
        rr <= 1'b1;
        @(posedge clk);
        rr <= 1'b0;
    endtask : rd

    task automatic pulse(input logic [7:0] b);
        ev <= b;
        @(posedge clk);
        ev <= 8'h00;
    endtask : pulse

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("status reset", est, 8'h80);
        rd(SEHC_CMD_ESEQ, 8'h00, "mask reset");
        rd(SEHC_CMD_ESRQ, 8'h80, "status");
        rd(SEHC_CMD_ESRQ, 8'h00, "status after read");
        $display("test reset done");
        foreach (vals[j]) begin
            cmd(SEHC_CMD_ESEW, vals[j], 1'b1);
            rd(SEHC_CMD_ESEQ, vals[j], "mask");
        end
        $display("test mask done");
        for (i = 0; i < 16; i++) begin
            ser <= i[3];
            pulse(8'h01 << i[2:0]);
            rd(SEHC_CMD_ESRQ, (8'h01 << i[2:0]) & (i[3] ? 8'hbc : 8'hff),
                "event bit");
        end
        $display("test weights done");
        ser <= 1'b0;
        pulse(8'h20);
        @(negedge clk);
        check("summary", summ, 1'b1);
        cmd(SEHC_CMD_CLS, 8'h00, 1'b0);
        @(negedge clk);
        check("clear pulse", sclr, 1'b1);
        check("summary", summ, 1'b0);
        rd(SEHC_CMD_ESEQ, 8'hff, "mask kept");
        $display("test clear done");
        for (i = 0; i < 2; i++) begin
            ser <= i[0];
            cmd(SEHC_CMD_OTHER, 8'h03, 1'b1);
            cmd(SEHC_CMD_OPC, 8'h00, 1'b0);
            rd(SEHC_CMD_ESRQ, {7'h00, !i[0]}, "complete bit");
        end
        $display("test complete done");
        cmd(SEHC_CMD_OTHER, 8'h06, 1'b1);
        cmd(SEHC_CMD_WAIT, 8'h00, 1'b0);
        @(negedge clk);
        check("payload", xd, 8'h06);
        for (k = 0; k < 60 && crd !== 1'b1; k++) @(negedge clk);
        check("held back", k, 10'd7);
        check("busy at resume", busy, 1'b0);
        $display("test wait done");
        test_done();
    end
endmodule : test_status_event_command_handling

`default_nettype wire
